// ==== hdl/rwd_defs.svh ====
// constants of the reset and watchdog unit
`ifndef RWD_DEFS_SVH
`define RWD_DEFS_SVH
// system clock period in ns (40 MHz)
`define RWD_CLK_NS 25
// least pin low time and least supply dip time, in ns
`define RWD_PIN_MIN_NS 2500
`define RWD_BOD_MIN_NS 2000
// least times rounded up to whole clock cycles
`define RWD_PIN_MIN_CYC ((`RWD_PIN_MIN_NS + `RWD_CLK_NS - 1) / `RWD_CLK_NS)
`define RWD_BOD_MIN_CYC ((`RWD_BOD_MIN_NS + `RWD_CLK_NS - 1) / `RWD_CLK_NS)
// register addresses
`define RWD_ADDR_CAUSE 2'h0
`define RWD_ADDR_CTRL 2'h1
// reset cause bit positions
`define RWD_POWER_UP_BIT 0
`define RWD_PIN_BIT 1
`define RWD_SUPPLY_BIT 2
`define RWD_WDOG_BIT 3
// watchdog control bit positions
`define RWD_WDP0_BIT 0
`define RWD_WDP2_BIT 2
`define RWD_RE_BIT 3
`define RWD_CE_BIT 4
`define RWD_WDP3_BIT 5
`define RWD_IE_BIT 6
`define RWD_IF_BIT 7
// largest legal prescale code, reserved codes act as this one
`define RWD_WDP_MAX 4'h9
// oscillator cycles of the shortest time-out
`define RWD_WDT_BASE 21'h000800
// change window length in system clock cycles
`define RWD_WIN_CYC 3'h4
// trip level code that leaves the supply monitor off
`define RWD_BOD_OFF 3'h7
`endif

// ==== hdl/rwd_pkg.sv ====
// types of the reset and watchdog unit
package rwd_pkg;
    // reset sequencer, gray coded along hold, delay, run
    typedef enum logic [1:0] {
        RWD_HOLD = 2'h0,
        RWD_DELAY = 2'h1,
        RWD_RUN = 2'h3
    } rwd_seq_t;

    // register port request
    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } rwd_bus_req_t;

    // non-volatile options
    typedef struct packed {
        logic pin_reset_disable_option;
        logic [2:0] supply_trip_level_option;
        logic watchdog_always_on_option;
    } rwd_fuse_t;

    // whole state of the unit
    typedef struct packed {
        rwd_seq_t seq;
        logic [15:0] dly_cnt;
        logic [7:0] pin_cnt;
        logic [7:0] bod_cnt;
        logic [3:0] cause;
        logic osc_q;
        logic [20:0] wd_cnt;
        logic wd_pulse;
        logic watchdog_reset_enable;
        logic watchdog_irq_enable;
        logic watchdog_irq_flag;
        logic watchdog_change_enable;
        logic [2:0] win_cnt;
        logic [3:0] watchdog_prescale_code;
        logic sys_reset_r;
        logic bandgap_en_r;
        logic wdt_irq_r;
        logic wdt_wake_r;
        logic [7:0] rd_data_r;
    } rwd_state_t;
endpackage : rwd_pkg

// ==== hdl/rwd_unit.sv ====
// reset sequencer, reset cause flags, bandgap enable and watchdog timer
//
// Notes on behaviour
// - long low pin pulse asserts reset
// - pin release waits full start-up delay
// - option disables pin as reset source
// - supply low resets, release waits delay
// - supply dips shorter than minimum ignored
// - watchdog reset is one-cycle pulse
// - cause bits 7..4 read zero
// - watchdog cause flag, cleared writing zero
// - supply cause flag, cleared writing zero
// - pin cause flag, cleared writing zero
// - power-up flag cleared only by software
// - bandgap on for monitor, comparator, converter
// - watchdog counts dedicated 128 kHz oscillator
// - restart strobe clears watchdog counter
// - interrupt mode: interrupt and wake, no reset
// - combined mode: interrupt first, then reset
// - always-on option forces reset mode
// - one write sets change and reset enables
// - clearing or prescale change only in window
// - time-out selectable from 16ms to 8s
// - watchdog flag forces reset enable high
// - change enable clears after four cycles
// - irq flag: set on expiry, cleared by ack
`timescale 1ns/100ps
`include "rwd_defs.svh"
module rwd_unit #(
    parameter logic [20:0] WDT_BASE_CYCLES = `RWD_WDT_BASE
) (
    // clock and power-up reset
    input wire logic core_clk,
    input wire logic rst,
    // register port
    input wire rwd_pkg::rwd_bus_req_t bus_req,
    output logic [7:0] rd_data,
    // reset sources and options
    input wire logic pin_reset_n,
    input wire logic supply_low,
    input wire rwd_pkg::rwd_fuse_t fuse,
    input wire logic [15:0] startup_delay_period,
    // watchdog oscillator and cpu events
    input wire logic wdt_osc_clk,
    input wire logic wdt_restart,
    input wire logic irq_vector_ack,
    // reference requests
    input wire logic comparator_ref_select,
    input wire logic adc_enabled,
    // outputs to the system
    output logic sys_reset,
    output logic bandgap_en,
    output logic wdt_irq,
    output logic wdt_wake
);
    import rwd_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // time-out in oscillator cycles for a prescale code
    function automatic logic [20:0] wd_limit(input logic [3:0] code);
        logic [3:0] c;
        c = (code > `RWD_WDP_MAX) ? `RWD_WDP_MAX : code;
        wd_limit = WDT_BASE_CYCLES << c;
    endfunction : wd_limit

    // saturating filter counter step
    function automatic logic [7:0] filt_step(input logic act, input logic [7:0] cnt,
                                             input logic [7:0] lim);
        if (!act) begin
            filt_step = 8'h00;
        end else if (cnt == lim) begin
            filt_step = cnt;
        end else begin
            filt_step = cnt + 8'h01;
        end
    endfunction : filt_step

    ////////////////////////////////////////////////////////////////////////
    // state

    localparam logic [7:0] PIN_MIN = 8'(`RWD_PIN_MIN_CYC);
    localparam logic [7:0] BOD_MIN = 8'(`RWD_BOD_MIN_CYC);

    rwd_state_t s_r;
    rwd_state_t s_nxt;

    logic tick;
    logic pin_act;
    logic bod_on;
    logic bod_act;
    logic src;
    logic always_on;
    logic wde_eff;
    logic watchdog_irq_enable_eff;
    logic wd_on;
    logic expire;
    logic wr_ctrl;
    logic wr_cause;
    logic [7:0] wd;

    ////////////////////////////////////////////////////////////////////////
    // next state

    // one process computes the whole next state
    always_comb begin
        s_nxt = s_r;
        wd = bus_req.wdata;
        wr_ctrl = bus_req.wr && (bus_req.addr == `RWD_ADDR_CTRL);
        wr_cause = bus_req.wr && (bus_req.addr == `RWD_ADDR_CAUSE);
        expire = 1'b0;

        // oscillator edge, sampled on the system clock
        s_nxt.osc_q = wdt_osc_clk;
        tick = wdt_osc_clk && !s_r.osc_q;

        // pin and supply filters
        s_nxt.pin_cnt = filt_step(!pin_reset_n, s_r.pin_cnt, PIN_MIN);
        pin_act = (s_r.pin_cnt == PIN_MIN) && !fuse.pin_reset_disable_option;
        bod_on = fuse.supply_trip_level_option != `RWD_BOD_OFF;
        s_nxt.bod_cnt = filt_step(supply_low && bod_on, s_r.bod_cnt, BOD_MIN);
        bod_act = s_r.bod_cnt == BOD_MIN;
        src = pin_act || bod_act || s_r.wd_pulse;

        // reset sequencer: hold while any source, then count delay
        if (src) begin
            s_nxt.seq = RWD_HOLD;
            s_nxt.dly_cnt = 16'h0000;
        end else begin
            unique case (s_r.seq)
                RWD_HOLD: s_nxt.seq = RWD_DELAY;
                RWD_DELAY: begin
                    if (s_r.dly_cnt >= startup_delay_period) begin
                        s_nxt.seq = RWD_RUN;
                    end else begin
                        s_nxt.dly_cnt = s_r.dly_cnt + 16'h0001;
                    end
                end
                RWD_RUN: s_nxt.seq = RWD_RUN;
                default: s_nxt.seq = RWD_HOLD;
            endcase
        end

        // effective watchdog mode
        always_on = fuse.watchdog_always_on_option;
        wde_eff = s_r.watchdog_reset_enable || s_r.cause[`RWD_WDOG_BIT] || always_on;
        watchdog_irq_enable_eff = s_r.watchdog_irq_enable && !always_on;
        wd_on = wde_eff || watchdog_irq_enable_eff;

        // watchdog counter
        if (wdt_restart || !wd_on) begin
            s_nxt.wd_cnt = 21'h000000;
        end else if (tick) begin
            if (s_r.wd_cnt >= wd_limit(s_r.watchdog_prescale_code) - 21'h000001) begin
                s_nxt.wd_cnt = 21'h000000;
                expire = 1'b1;
            end else begin
                s_nxt.wd_cnt = s_r.wd_cnt + 21'h000001;
            end
        end

        // change window countdown
        if (s_r.watchdog_change_enable) begin
            s_nxt.win_cnt = s_r.win_cnt - 3'h1;
            if (s_r.win_cnt == 3'h1) begin
                s_nxt.watchdog_change_enable = 1'b0;
            end
        end

        // watchdog control writes
        if (wr_ctrl) begin
            if (!always_on) begin
                s_nxt.watchdog_irq_enable = wd[`RWD_IE_BIT];
            end
            if (wd[`RWD_IF_BIT]) begin
                s_nxt.watchdog_irq_flag = 1'b0;
            end
            if (wd[`RWD_CE_BIT] && wd[`RWD_RE_BIT]) begin
                s_nxt.watchdog_change_enable = 1'b1;
                s_nxt.watchdog_reset_enable = 1'b1;
                s_nxt.win_cnt = `RWD_WIN_CYC;
            end else if (s_r.watchdog_change_enable && !wd[`RWD_CE_BIT]) begin
                s_nxt.watchdog_reset_enable = wd[`RWD_RE_BIT];
                s_nxt.watchdog_prescale_code = {wd[`RWD_WDP3_BIT], wd[`RWD_WDP2_BIT:`RWD_WDP0_BIT]};
                s_nxt.watchdog_change_enable = 1'b0;
                s_nxt.win_cnt = 3'h0;
            end else if (wd[`RWD_RE_BIT]) begin
                s_nxt.watchdog_reset_enable = 1'b1;
            end
        end

        // vector execution clears the flag, and in combined mode the enable
        if (irq_vector_ack) begin
            s_nxt.watchdog_irq_flag = 1'b0;
            if (wde_eff) begin
                s_nxt.watchdog_irq_enable = 1'b0;
            end
        end

        // expiry action, set wins over any clear above
        s_nxt.wd_pulse = 1'b0;
        s_nxt.wdt_wake_r = 1'b0;
        if (expire) begin
            if (watchdog_irq_enable_eff && !(wde_eff && s_r.watchdog_irq_flag)) begin
                s_nxt.watchdog_irq_flag = 1'b1;
                s_nxt.wdt_wake_r = 1'b1;
            end else if (wde_eff) begin
                s_nxt.wd_pulse = 1'b1;
            end
        end

        // cause flags: software writes zero to clear, hardware set wins
        if (wr_cause) begin
            s_nxt.cause = s_r.cause & wd[3:0];
        end
        if (pin_act) begin
            s_nxt.cause[`RWD_PIN_BIT] = 1'b1;
        end
        if (bod_act) begin
            s_nxt.cause[`RWD_SUPPLY_BIT] = 1'b1;
        end
        if (s_r.wd_pulse) begin
            s_nxt.cause[`RWD_WDOG_BIT] = 1'b1;
        end

        // internal reset returns watchdog settings to their initial values
        if (s_r.sys_reset_r) begin
            s_nxt.watchdog_reset_enable = 1'b0;
            s_nxt.watchdog_irq_enable = 1'b0;
            s_nxt.watchdog_irq_flag = 1'b0;
            s_nxt.watchdog_change_enable = 1'b0;
            s_nxt.win_cnt = 3'h0;
            s_nxt.watchdog_prescale_code = 4'h0;
            s_nxt.wd_cnt = 21'h000000;
        end

        // registered outputs
        s_nxt.sys_reset_r = s_nxt.seq != RWD_RUN;
        s_nxt.bandgap_en_r = bod_on || comparator_ref_select || adc_enabled;
        s_nxt.wdt_irq_r = s_nxt.watchdog_irq_flag && s_nxt.watchdog_irq_enable && !always_on;

        // read data valid only in the cycle after the strobe
        s_nxt.rd_data_r = 8'h00;
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                `RWD_ADDR_CAUSE: s_nxt.rd_data_r = {4'h0, s_r.cause};
                `RWD_ADDR_CTRL: s_nxt.rd_data_r = {s_r.watchdog_irq_flag, watchdog_irq_enable_eff, s_r.watchdog_prescale_code[3], s_r.watchdog_change_enable,
                                                   wde_eff, s_r.watchdog_prescale_code[2:0]};
                default: s_nxt.rd_data_r = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    // power-up reset: only the power-up flag is set, reset held
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_r <= '0;
            s_r.seq <= RWD_HOLD;
            s_r.cause <= 4'h1;
            s_r.sys_reset_r <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from flip-flops
    assign sys_reset = s_r.sys_reset_r;
    assign bandgap_en = s_r.bandgap_en_r;
    assign wdt_irq = s_r.wdt_irq_r;
    assign wdt_wake = s_r.wdt_wake_r;
    assign rd_data = s_r.rd_data_r;
endmodule : rwd_unit

// ==== verification/rwd_unit_props.sv ====
// property checker of the reset and watchdog unit
`timescale 1ns/100ps
module rwd_unit_props #(
    parameter logic [20:0] WDT_BASE_CYCLES = 21'h000800
) (
    // clock, reset and register port
    input wire logic core_clk,
    input wire logic rst,
    input wire rwd_pkg::rwd_bus_req_t bus_req,
    input wire logic [7:0] rd_data,
    // sources, options and events
    input wire logic pin_reset_n,
    input wire logic supply_low,
    input wire rwd_pkg::rwd_fuse_t fuse,
    input wire logic [15:0] startup_delay_period,
    input wire logic wdt_osc_clk,
    input wire logic wdt_restart,
    input wire logic irq_vector_ack,
    input wire logic comparator_ref_select,
    input wire logic adc_enabled,
    // outputs
    input wire logic sys_reset,
    input wire logic bandgap_en,
    input wire logic wdt_irq,
    input wire logic wdt_wake
);
    import rwd_pkg::*;
    logic [7:0] pin_lo_r;
    logic [7:0] sup_lo_r;
    logic [16:0] hold_r;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // run lengths of active sources and of reset held high
    always_ff @(posedge core_clk) begin
        pin_lo_r <= (pin_reset_n || fuse.pin_reset_disable_option) ? 8'h00
            : pin_lo_r + {7'h00, pin_lo_r != 8'hFF};
        sup_lo_r <= (!supply_low || fuse.supply_trip_level_option == 3'h7) ? 8'h00
            : sup_lo_r + {7'h00, sup_lo_r != 8'hFF};
        hold_r <= (rst || !sys_reset) ? 17'h00000 : hold_r + 17'h00001;
    end
    sequence s_wake;
        wdt_wake ##1 wdt_irq;
    endsequence
    property p_bandgap;
        !$past(rst) |-> bandgap_en == ($past(fuse.supply_trip_level_option) != 3'h7
            || $past(comparator_ref_select) || $past(adc_enabled));
    endproperty
    a_bandgap: assert property (p_bandgap) else $error("bandgap enable wrong");
    property p_cause_top;
        $past(bus_req.rd) && $past(bus_req.addr) == 2'h0 |-> rd_data[7:4] == 4'h0;
    endproperty
    a_cause_top: assert property (p_cause_top) else $error("cause top bits set");
    property p_rd_idle;
        !$past(bus_req.rd) |-> rd_data == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
    property p_pin;
        pin_lo_r > 8'h65 |-> sys_reset;
    endproperty
    a_pin: assert property (p_pin) else $error("long pin low gave no reset");
    property p_supply;
        sup_lo_r > 8'h51 |-> sys_reset;
    endproperty
    a_supply: assert property (p_supply) else $error("supply low gave no reset");
    property p_release;
        $fell(sys_reset) |-> $past(hold_r) > {1'b0, startup_delay_period};
    endproperty
    a_release: assert property (p_release) else $error("reset released early");
    property p_wake_irq;
        wdt_wake |-> s_wake;
    endproperty
    a_wake_irq: assert property (p_wake_irq) else $error("no request after wake");
    property p_wake_pulse;
        wdt_wake |=> !wdt_wake;
    endproperty
    a_wake_pulse: assert property (p_wake_pulse) else $error("wake longer than one");
    property p_wake_no_reset;
        wdt_wake && !sys_reset |=> !sys_reset;
    endproperty
    a_wake_no_reset: assert property (p_wake_no_reset) else $error("reset on wake");
    property p_always_on;
        fuse.watchdog_always_on_option && $past(fuse.watchdog_always_on_option)
            |-> !wdt_irq && !wdt_wake;
    endproperty
    a_always_on: assert property (p_always_on) else $error("irq while always on");
endmodule : rwd_unit_props
bind rwd_unit rwd_unit_props #(.WDT_BASE_CYCLES(WDT_BASE_CYCLES)) u_props (
    .core_clk(core_clk), .rst(rst), .bus_req(bus_req), .rd_data(rd_data),
    .pin_reset_n(pin_reset_n), .supply_low(supply_low), .fuse(fuse),
    .startup_delay_period(startup_delay_period), .wdt_osc_clk(wdt_osc_clk),
    .wdt_restart(wdt_restart), .irq_vector_ack(irq_vector_ack),
    .comparator_ref_select(comparator_ref_select), .adc_enabled(adc_enabled),
    .sys_reset(sys_reset), .bandgap_en(bandgap_en), .wdt_irq(wdt_irq), .wdt_wake(wdt_wake));

// ==== verification/tb_rwd_unit.sv ====
// self-checking bench of the reset and watchdog unit
`timescale 1ns/100ps
module tb_rwd_unit;
    import rwd_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    rwd_bus_req_t bus_req = '0;
    rwd_fuse_t fuse = 5'h0E; // pin on, monitor off, option off
    logic pin_reset_n = 1'b1;
    logic supply_low = 1'b0;
    logic wdt_osc_clk = 1'b0;
    logic wdt_restart = 1'b0;
    logic irq_vector_ack = 1'b0;
    logic comparator_ref_select = 1'b0;
    logic adc_enabled = 1'b0;
    logic [15:0] dly_per = 16'h0014;
    logic [7:0] rd_data;
    logic sys_reset, bandgap_en, wdt_irq, wdt_wake;
    logic [7:0] exp_q[$];
    logic rd_q = 1'b0;
    logic [31:0] seed = 32'h0000B8F0;
    int failures = 0;
    int n_tests = 0;
    int osc_n = 0;
    int wakes = 0;
    rwd_unit #(.WDT_BASE_CYCLES(21'h000008)) dut (.core_clk(core_clk), .rst(rst),
        .bus_req(bus_req), .rd_data(rd_data), .pin_reset_n(pin_reset_n),
        .supply_low(supply_low), .fuse(fuse), .startup_delay_period(dly_per),
        .wdt_osc_clk(wdt_osc_clk), .wdt_restart(wdt_restart), .irq_vector_ack(irq_vector_ack),
        .comparator_ref_select(comparator_ref_select), .adc_enabled(adc_enabled),
        .sys_reset(sys_reset), .bandgap_en(bandgap_en), .wdt_irq(wdt_irq), .wdt_wake(wdt_wake));
    // clock of 25 ns
    initial begin
        forever #12.5 core_clk = ~core_clk;
    end
    // oscillator near 128 kHz, wake counter, read result watcher
    always @(posedge core_clk) begin
        osc_n <= (osc_n == 155) ? 0 : osc_n + 1;
        wdt_osc_clk <= (osc_n == 155) ? ~wdt_osc_clk : wdt_osc_clk;
        wakes <= wakes + (wdt_wake === 1'b1);
        if (rd_q) chk8(exp_q.pop_front(), rd_data);
        rd_q <= bus_req.rd;
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk8(input logic [7:0] e, input logic [7:0] s);
        n_tests++;
        if (s !== e) begin
            failures++;
            $display("[ERR] rd_data exp %h seen %h", e, s);
        end
    endtask : chk8
    task automatic chk1(input string nm, input logic e, input logic s);
        n_tests++;
        if (s !== e) begin
            failures++;
            $display("[ERR] %s exp %b seen %b", nm, e, s);
        end
    endtask : chk1
    task automatic test_done();
        $display("compares %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done
    // idle cycles, the bus strobes dropped
    task automatic cyc(input int n);
        bus_req.wr <= 1'b0;
        bus_req.rd <= 1'b0;
        repeat (n) @(posedge core_clk);
    endtask : cyc
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
    endtask : wr
    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        exp_q.push_back(e);
        @(posedge core_clk);
    endtask : rd
    // pin low (s 0) or supply low (s 1) for len cycles
    task automatic hold_src(input int s, input int len);
        {pin_reset_n, supply_low} <= (s == 0) ? 2'b00 : 2'b11;
        cyc(len);
        {pin_reset_n, supply_low} <= 2'b10;
    endtask : hold_src
    // bounded wait on sys_reset (w 0) or wdt_wake (w 1)
    task automatic wait_on(input int w, input logic v);
        int n;
        n = 0;
        // strobes stay one cycle long while waiting
        bus_req.wr <= 1'b0;
        bus_req.rd <= 1'b0;
        while (((w == 0) ? sys_reset : wdt_wake) !== v && n < 6000) begin
            @(posedge core_clk);
            n++;
        end
        if (n == 6000) begin
            failures++;
            $display("[ERR] wait %0d exp %b seen timeout", w, v);
            test_done();
        end
    endtask : wait_on
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        cyc(5);
        rst <= 1'b0;
        wait_on(0, 1'b0);
        rd(2'h0, 8'h01);
        rd(2'h2, 8'h00);
        seed = lfsr(seed);
        hold_src(0, 1 + seed[5:0]);
        cyc(2);
        chk1("sys_reset", 1'b0, sys_reset);
        hold_src(0, 120);
        chk1("sys_reset", 1'b1, sys_reset);
        wait_on(0, 1'b0);
        rd(2'h0, 8'h03);
        wr(2'h0, {seed[7:4], 4'hD});
        rd(2'h0, 8'h01);
        wr(2'h0, 8'h00);
        rd(2'h0, 8'h00);
        fuse.pin_reset_disable_option <= 1'b1;
        hold_src(0, 120);
        chk1("sys_reset", 1'b0, sys_reset);
        cyc(2);
        fuse.pin_reset_disable_option <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            fuse.supply_trip_level_option <= i[0] ? 3'h4 : 3'h7;
            comparator_ref_select <= i[1];
            adc_enabled <= i[2];
            cyc(2);
            chk1("bandgap_en", i != 0, bandgap_en);
        end
        seed = lfsr(seed);
        dly_per <= {8'h00, seed[15:8]};
        hold_src(1, 1 + seed[5:0]);
        cyc(2);
        chk1("sys_reset", 1'b0, sys_reset);
        hold_src(1, 100);
        chk1("sys_reset", 1'b1, sys_reset);
        wait_on(0, 1'b0);
        rd(2'h0, 8'h04);
        wr(2'h0, 8'h00);
        wr(2'h1, 8'h40);
        repeat (3) begin
            cyc(1500);
            wdt_restart <= 1'b1;
            cyc(1);
            wdt_restart <= 1'b0;
        end
        chk1("no_wake", 1'b1, wakes == 0);
        wait_on(1, 1'b1);
        cyc(1);
        chk1("wdt_irq", 1'b1, wdt_irq);
        rd(2'h1, 8'hC0);
        irq_vector_ack <= 1'b1;
        cyc(1);
        irq_vector_ack <= 1'b0;
        rd(2'h1, 8'h40);
        wr(2'h1, 8'h00);
        wr(2'h1, 8'h18);
        rd(2'h1, 8'h18);
        cyc(3);
        rd(2'h1, 8'h08);
        wr(2'h1, 8'h01);
        rd(2'h1, 8'h08);
        wr(2'h1, 8'h18);
        wr(2'h1, 8'h01);
        rd(2'h1, 8'h01);
        wr(2'h1, 8'h09);
        wait_on(0, 1'b1);
        wait_on(0, 1'b0);
        rd(2'h0, 8'h08);
        wr(2'h1, 8'h18);
        wr(2'h1, 8'h00);
        rd(2'h1, 8'h08);
        wr(2'h0, 8'h00);
        rd(2'h1, 8'h00);
        wr(2'h1, 8'h48);
        wait_on(1, 1'b1);
        wait_on(0, 1'b1);
        wait_on(0, 1'b0);
        wr(2'h0, 8'h00);
        fuse.watchdog_always_on_option <= 1'b1;
        cyc(2);
        wr(2'h1, 8'h40);
        rd(2'h1, 8'h08);
        fuse.watchdog_always_on_option <= 1'b0;
        cyc(3);
        test_done();
    end
endmodule : tb_rwd_unit
